// ### hw/cpm_pkg.sv
package cpm_pkg;
  localparam int MODE_W = 7;
  localparam int CAP_W = 3;
  localparam int WAY_GRP = 4;
  localparam logic [MODE_W-1:0] MODE_FULL_ON = 7'h48;
  localparam logic [MODE_W-1:0] MODE_Q3_ON = 7'h38;
  localparam logic [MODE_W-1:0] MODE_HALF_ON = 7'h28;
  localparam logic [MODE_W-1:0] MODE_Q1_ON = 7'h18;
  localparam logic [MODE_W-1:0] MODE_SF_ON = 7'h08;
  localparam logic [MODE_W-1:0] MODE_FULL_FRET = 7'h47;
  localparam logic [MODE_W-1:0] MODE_Q3_FRET = 7'h37;
  localparam logic [MODE_W-1:0] MODE_HALF_FRET = 7'h27;
  localparam logic [MODE_W-1:0] MODE_Q1_FRET = 7'h17;
  localparam logic [MODE_W-1:0] MODE_SF_FRET = 7'h07;
  localparam logic [MODE_W-1:0] MODE_FULL_MRET = 7'h42;
  localparam logic [MODE_W-1:0] MODE_Q3_MRET = 7'h32;
  localparam logic [MODE_W-1:0] MODE_HALF_MRET = 7'h22;
  localparam logic [MODE_W-1:0] MODE_Q1_MRET = 7'h12;
  localparam logic [MODE_W-1:0] MODE_OFF = 7'h00;
  // Debug recovery class code in low bits; value is arbitrary
  localparam logic [3:0] CLS_DBG = 4'h1;
  localparam logic [3:0] CLS_ON = 4'h8;
  localparam logic [3:0] CLS_FRET = 4'h7;
  localparam logic [3:0] CLS_MRET = 4'h2;
  localparam logic [3:0] CLS_OFF = 4'h0;
  localparam int CAP_LSB = 4;
  localparam logic [CAP_W-1:0] CAP_FULL = 3'h4;
  localparam logic [7:0] RESET_INIT_MODE = 8'h00;
  // Cycles per way-group maintenance step
  localparam logic [7:0] WAY_OP_CYCLES = 8'h10;
  localparam logic [7:0] SF_INIT_CYCLES = 8'h20;
  localparam logic [7:0] DRAIN_CYCLES = 8'h04;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  // Synchroniser fill time before the start mode may be read
  localparam logic [7:0] INIT_SETTLE = 8'h04;
  typedef enum logic [1:0] {CPM_IDLE, CPM_WORK, CPM_ACK, CPM_DONE}
    cpm_hs_e;
endpackage

// ### hw/cpm_rst_sync.sv
`timescale 1ns/1ps
module cpm_rst_sync (
  input wire logic clock,
  input wire logic resetn,
  output logic rst_n_sync
);
  logic s1_r;
  logic s2_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= 1'b1;
      s2_r <= s1_r;
    end
  end
  assign rst_n_sync = s2_r;
endmodule // cpm_rst_sync

// ### hw/cpm_sync3.sv
`timescale 1ns/1ps
module cpm_sync3 #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // Third stage must agree with second before the value moves on
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;
  always_comb begin
    q_nxt = q_r;
    if (s2_r == s3_r) begin
      q_nxt = s3_r;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end
  assign q = q_r;
endmodule // cpm_sync3

// ### hw/cpm_mode_fsm.sv
`timescale 1ns/1ps
module cpm_mode_fsm
  import cpm_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [cpm_pkg::MODE_W-1:0] requested_mode_bus,
  input wire logic mode_request,
  input wire logic cores_all_off,
  input wire logic service_demand,
  input wire logic idle_hint,
  input wire logic memory_retention_wanted,
  input wire logic mem_idle,
  output logic mode_accept,
  output logic mode_deny,
  output logic [cpm_pkg::MODE_W-1:0] required_mode_hint,
  output logic [cpm_pkg::MODE_W-1:0] current_mode,
  output logic logic_power_on,
  output logic sf_ram_on,
  output logic [cpm_pkg::WAY_GRP-1:0] way_power_on,
  output logic ram_retention,
  output logic ram_clock_en,
  output logic coherent,
  output logic l3_alloc_en,
  output logic invalidate_busy,
  output logic request_stall,
  output logic debug_recovery_mode
);
  import cpm_pkg::*;

  logic rst_n;
  logic [MODE_W-1:0] req_mode_s;
  logic [2:0] ctl_s;
  logic req_s;
  logic all_off_s;
  logic demand_s;
  logic idle_s;
  logic mret_s;
  logic midle_s;

  cpm_rst_sync u_rst (
    .clock(clock),
    .resetn(resetn),
    .rst_n_sync(rst_n)
  );
  cpm_sync3 #(.W(MODE_W)) u_sync_mode (
    .clock(clock),
    .rst_n(rst_n),
    .d(requested_mode_bus),
    .q(req_mode_s)
  );
  cpm_sync3 #(.W(3)) u_sync_ctl (
    .clock(clock),
    .rst_n(rst_n),
    .d({mode_request, cores_all_off, service_demand}),
    .q(ctl_s)
  );
  cpm_sync3 #(.W(3)) u_sync_misc (
    .clock(clock),
    .rst_n(rst_n),
    .d({idle_hint, memory_retention_wanted, mem_idle}),
    .q({idle_s, mret_s, midle_s})
  );
  assign req_s = ctl_s[2];
  assign all_off_s = ctl_s[1];
  assign demand_s = ctl_s[0];

  function automatic logic [3:0] cls_of(input logic [MODE_W-1:0] m);
    cls_of = m[3:0];
  endfunction
  function automatic logic [CAP_W-1:0] cap_of(input logic [MODE_W-1:0] m);
    cap_of = m[MODE_W-1:CAP_LSB];
  endfunction
  function automatic logic [MODE_W-1:0] mk(input logic [CAP_W-1:0] c,
                                           input logic [3:0] k);
    mk = {c, k};
  endfunction
  function automatic logic is_legal_mode(input logic [MODE_W-1:0] m);
    logic [3:0] k;
    logic [CAP_W-1:0] c;
    k = cls_of(m);
    c = cap_of(m);
    is_legal_mode = 1'b0;
    if (c <= CAP_FULL) begin
      if (k == CLS_ON || k == CLS_FRET || k == CLS_DBG) begin
        is_legal_mode = 1'b1;
      end else if (k == CLS_MRET) begin
        is_legal_mode = (c != 3'h0);
      end else if (k == CLS_OFF) begin
        is_legal_mode = (c == 3'h0);
      end
    end
  endfunction
  // Single permitted step from cur to nxt
  function automatic logic step_ok(input logic [MODE_W-1:0] cur,
                                   input logic [MODE_W-1:0] nxt);
    logic [3:0] kc;
    logic [3:0] kn;
    logic [CAP_W-1:0] cc;
    logic [CAP_W-1:0] cn;
    kc = cls_of(cur);
    kn = cls_of(nxt);
    cc = cap_of(cur);
    cn = cap_of(nxt);
    step_ok = 1'b0;
    if (!is_legal_mode(nxt)) begin
      step_ok = 1'b0;
    end else if (kn == CLS_DBG) begin
      step_ok = 1'b1;
    end else if (kc == CLS_ON && kn == CLS_ON) begin
      step_ok = (cn == cc + 3'h1) || (cc == cn + 3'h1);
    end else if (kc == CLS_ON) begin
      step_ok = (kn == CLS_FRET && cn == cc) || (kn == CLS_OFF) ||
                (kn == CLS_MRET && cn == cc);
    end else if (kc == CLS_FRET || kc == CLS_MRET) begin
      step_ok = (kn == CLS_ON && cn == cc) ||
                (kc == CLS_MRET && kn == CLS_OFF);
    end else if (kc == CLS_OFF || kc == CLS_DBG) begin
      step_ok = (kn == CLS_ON);
    end
  endfunction

  cpm_hs_e hs_r;
  cpm_hs_e hs_nxt;
  logic [MODE_W-1:0] cur_r;
  logic [MODE_W-1:0] cur_nxt;
  logic [MODE_W-1:0] tgt_r;
  logic [MODE_W-1:0] tgt_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic acc_r;
  logic acc_nxt;
  logic deny_r;
  logic deny_nxt;
  logic dbg_keep_r;
  logic dbg_keep_nxt;
  logic init_r;
  logic init_nxt;
  logic [MODE_W-1:0] hint_r;
  logic [MODE_W-1:0] hint_nxt;
  logic inv_r;
  logic inv_nxt;
  logic alloc_r;
  logic alloc_nxt;

  // Work needed for a transition, in cycles
  function automatic logic [7:0] work_of(input logic [MODE_W-1:0] cur,
                                         input logic [MODE_W-1:0] nxt,
                                         input logic keep);
    logic [3:0] kc;
    logic [3:0] kn;
    kc = cls_of(cur);
    kn = cls_of(nxt);
    work_of = DRAIN_CYCLES;
    if (kn == CLS_DBG) begin
      work_of = CNT_ZERO;
    end else if (kc == CLS_OFF && kn == CLS_ON) begin
      work_of = keep ? DRAIN_CYCLES : SF_INIT_CYCLES;
    end else if (kc == CLS_MRET && kn == CLS_ON) begin
      work_of = SF_INIT_CYCLES;
    end else if (kc == CLS_ON && kn == CLS_ON) begin
      work_of = WAY_OP_CYCLES;
    end else if (kc == CLS_ON && kn == CLS_OFF) begin
      work_of = 8'(SF_INIT_CYCLES + WAY_OP_CYCLES);
    end
  endfunction

  always_comb begin
    hs_nxt = hs_r;
    cur_nxt = cur_r;
    tgt_nxt = tgt_r;
    cnt_nxt = cnt_r;
    acc_nxt = acc_r;
    deny_nxt = deny_r;
    dbg_keep_nxt = dbg_keep_r;
    init_nxt = init_r;
    alloc_nxt = alloc_r;
    inv_nxt = 1'b0;
    case (hs_r)
      CPM_IDLE: begin
        if (init_r) begin
          if (cnt_r != CNT_ZERO) begin
            cnt_nxt = cnt_r - 8'h01;
          end else begin
            cur_nxt = req_mode_s;
            dbg_keep_nxt = (cls_of(req_mode_s) == CLS_DBG);
            inv_nxt = (cls_of(req_mode_s) == CLS_ON);
            init_nxt = 1'b0;
          end
        end else if (req_s) begin
          tgt_nxt = req_mode_s;
          if (!step_ok(cur_r, req_mode_s)) begin
            deny_nxt = 1'b1;
            hs_nxt = CPM_ACK;
          end else if ((cls_of(req_mode_s) == CLS_MRET ||
                        cls_of(req_mode_s) == CLS_OFF) && !all_off_s) begin
            deny_nxt = 1'b1;
            hs_nxt = CPM_ACK;
          end else if (cls_of(req_mode_s) == CLS_DBG) begin
            cur_nxt = req_mode_s;
            dbg_keep_nxt = 1'b1;
            acc_nxt = 1'b1;
            hs_nxt = CPM_ACK;
          end else begin
            cnt_nxt = work_of(cur_r, req_mode_s, dbg_keep_r);
            if (cls_of(req_mode_s) == CLS_OFF) begin
              alloc_nxt = 1'b0;
            end
            hs_nxt = CPM_WORK;
          end
        end
      end
      CPM_WORK: begin
        // Drain waits on the memory system before counting down
        inv_nxt = (cls_of(cur_r) == CLS_OFF) && !dbg_keep_r;
        if (midle_s) begin
          if (cnt_r != CNT_ZERO) begin
            cnt_nxt = cnt_r - 8'h01;
          end else begin
            cur_nxt = tgt_r;
            acc_nxt = 1'b1;
            if (cls_of(tgt_r) == CLS_ON) begin
              dbg_keep_nxt = 1'b0;
              alloc_nxt = 1'b1;
            end
            hs_nxt = CPM_ACK;
          end
        end
      end
      CPM_ACK: begin
        if (!req_s) begin
          acc_nxt = 1'b0;
          deny_nxt = 1'b0;
          hs_nxt = CPM_IDLE;
        end
      end
      default: begin
        hs_nxt = CPM_IDLE;
      end
    endcase
  end

  // Hint picks one neighbour of the current mode only
  always_comb begin
    logic [3:0] k;
    logic [CAP_W-1:0] c;
    k = cls_of(cur_r);
    c = cap_of(cur_r);
    hint_nxt = cur_r;
    if (k == CLS_FRET) begin
      if (demand_s) begin
        hint_nxt = mk(c, CLS_ON);
      end
    end else if (k == CLS_ON) begin
      if (mret_s && all_off_s && idle_s && c != 3'h0) begin
        hint_nxt = mk(c, CLS_MRET);
      end else if (idle_s && !demand_s) begin
        hint_nxt = mk(c, CLS_FRET);
      end
    end else if (k == CLS_DBG || k == CLS_OFF || k == CLS_MRET) begin
      if (demand_s) begin
        hint_nxt = mk(c == 3'h0 ? CAP_FULL : c, CLS_ON);
      end
    end
    if (!step_ok(cur_r, hint_nxt)) begin
      hint_nxt = cur_r;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hs_r <= CPM_IDLE;
      cur_r <= MODE_OFF;
      tgt_r <= MODE_OFF;
      cnt_r <= INIT_SETTLE;
      acc_r <= 1'b0;
      deny_r <= 1'b0;
      dbg_keep_r <= 1'b0;
      init_r <= 1'b1;
      hint_r <= MODE_OFF;
      inv_r <= 1'b0;
      alloc_r <= 1'b0;
    end else begin
      hs_r <= hs_nxt;
      cur_r <= cur_nxt;
      tgt_r <= tgt_nxt;
      cnt_r <= cnt_nxt;
      acc_r <= acc_nxt;
      deny_r <= deny_nxt;
      dbg_keep_r <= dbg_keep_nxt;
      init_r <= init_nxt;
      hint_r <= hint_nxt;
      inv_r <= inv_nxt;
      alloc_r <= alloc_nxt;
    end
  end

  logic [3:0] kc_o;
  logic [CAP_W-1:0] cc_o;
  logic pw_logic_r;
  logic sf_r;
  logic [WAY_GRP-1:0] way_r;
  logic ret_r;
  logic rclk_r;
  logic coh_r;
  logic stall_r;
  assign kc_o = cls_of(cur_r);
  assign cc_o = cap_of(cur_r);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pw_logic_r <= 1'b0;
      sf_r <= 1'b0;
      way_r <= '0;
      ret_r <= 1'b0;
      rclk_r <= 1'b0;
      coh_r <= 1'b0;
      stall_r <= 1'b0;
    end else begin
      pw_logic_r <= (kc_o == CLS_ON) || (kc_o == CLS_FRET) ||
                    (kc_o == CLS_DBG);
      sf_r <= (kc_o == CLS_ON) || (kc_o == CLS_FRET);
      for (int i = 0; i < WAY_GRP; i++) begin
        way_r[i] <= (kc_o != CLS_OFF) && (32'(cc_o) > i);
      end
      ret_r <= (kc_o == CLS_FRET) || (kc_o == CLS_MRET);
      rclk_r <= (kc_o == CLS_ON);
      coh_r <= (kc_o == CLS_ON) && (hs_r != CPM_WORK ||
               cls_of(tgt_r) == CLS_ON);
      stall_r <= demand_s && (kc_o != CLS_ON);
    end
  end

  assign mode_accept = acc_r;
  assign mode_deny = deny_r;
  assign required_mode_hint = hint_r;
  assign current_mode = cur_r;
  assign logic_power_on = pw_logic_r;
  assign sf_ram_on = sf_r;
  assign way_power_on = way_r;
  assign ram_retention = ret_r;
  assign ram_clock_en = rclk_r;
  assign coherent = coh_r;
  assign l3_alloc_en = alloc_r;
  assign invalidate_busy = inv_r;
  assign request_stall = stall_r;
  assign debug_recovery_mode = dbg_keep_r;
endmodule // cpm_mode_fsm

// ### verif/cpm_mode_fsm_assertions.sv
`timescale 1ns/1ps
module cpm_mode_fsm_chk
  import cpm_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [cpm_pkg::MODE_W-1:0] requested_mode_bus,
  input wire logic mode_request,
  input wire logic cores_all_off,
  input wire logic service_demand,
  input wire logic mode_accept,
  input wire logic mode_deny,
  input wire logic [cpm_pkg::MODE_W-1:0] required_mode_hint,
  input wire logic [cpm_pkg::MODE_W-1:0] current_mode,
  input wire logic logic_power_on,
  input wire logic sf_ram_on,
  input wire logic ram_retention,
  input wire logic ram_clock_en,
  input wire logic invalidate_busy,
  input wire logic debug_recovery_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire logic [3:0] ck = current_mode[3:0];
  wire logic [2:0] cc = current_mode[6:4];
  wire logic [2:0] hc = required_mode_hint[6:4];
  wire logic step_ok = hc == cc || hc == cc + 3'h1 || cc == hc + 3'h1;
  // Quiet windows only: powers follow current_mode one cycle late
  sequence on_quiet;
    (ck == CLS_ON && !mode_request)[*8];
  endsequence
  sequence fret_quiet;
    (ck == CLS_FRET && !mode_request)[*8];
  endsequence
  sequence dbg_asked;
    mode_request && requested_mode_bus[3:0] == CLS_DBG
      && !mode_accept && !mode_deny;
  endsequence
  resp_excl_a: assert property (!(mode_accept && mode_deny))
    else $error("accept and deny together");
  resp_hold_a: assert property (
    $rose(mode_accept) |-> mode_accept[*3])
    else $error("accept dropped early");
  deny_keep_a: assert property (mode_deny |-> $stable(current_mode))
    else $error("mode moved on deny");
  hint_step_a: assert property (
    required_mode_hint[3:0] == CLS_ON && ck == CLS_ON |-> step_ok)
    else $error("hint not one step away");
  on_power_a: assert property (
    on_quiet |-> logic_power_on && sf_ram_on)
    else $error("logic or filter unpowered in on mode");
  fret_gate_a: assert property (
    fret_quiet |-> ram_retention && !ram_clock_en)
    else $error("retention clock not gated");
  demand_on_a: assert property (
    ck == CLS_FRET && service_demand
      |-> ##[1:8] required_mode_hint == {cc, CLS_ON})
    else $error("demand did not ask for on");
  mret_entry_a: assert property (
    $changed(ck) && ck == CLS_MRET |-> cores_all_off)
    else $error("memory retention with cores on");
  dbg_now_a: assert property (dbg_asked |-> ##[1:10] mode_accept)
    else $error("debug request not accepted");
  dbg_keep_a: assert property (
    debug_recovery_mode |-> !invalidate_busy)
    else $error("invalidation in debug recovery");
endmodule // cpm_mode_fsm_chk
bind cpm_mode_fsm cpm_mode_fsm_chk i_chk (
  .clock(clock), .resetn(resetn),
  .requested_mode_bus(requested_mode_bus), .mode_request(mode_request),
  .cores_all_off(cores_all_off), .service_demand(service_demand),
  .mode_accept(mode_accept), .mode_deny(mode_deny),
  .required_mode_hint(required_mode_hint), .current_mode(current_mode),
  .logic_power_on(logic_power_on), .sf_ram_on(sf_ram_on),
  .ram_retention(ram_retention), .ram_clock_en(ram_clock_en),
  .invalidate_busy(invalidate_busy),
  .debug_recovery_mode(debug_recovery_mode)
);

// ### verif/cpm_ctrl_model.sv
`timescale 1ns/1ps
module cpm_ctrl_model
  import cpm_pkg::*;
(
  input wire logic clock,
  input wire logic mode_accept,
  input wire logic mode_deny,
  output logic [cpm_pkg::MODE_W-1:0] requested_mode_bus,
  output logic mode_request
);
  initial begin
    requested_mode_bus = MODE_OFF;
    mode_request = 1'b0;
  end
  // Bus value held over reset release is the starting mode
  task automatic preset(input logic [MODE_W-1:0] m);
    requested_mode_bus <= m;
  endtask
  // Slow start stands for system actions done before raising power
  task automatic request(input logic [MODE_W-1:0] m, input int slow);
    int n;
    n = 0;
    repeat (slow) @(posedge clock);
    requested_mode_bus <= m;
    mode_request <= 1'b1;
    @(posedge clock);
    while (!mode_accept && !mode_deny && n < 4000) begin
      @(posedge clock);
      n++;
    end
    mode_request <= 1'b0;
    while ((mode_accept || mode_deny) && n < 8000) begin
      @(posedge clock);
      n++;
    end
  endtask
endmodule // cpm_ctrl_model

// ### verif/cluster_power_mode_fsm_tb_top.sv
`timescale 1ns/1ps
module cluster_power_mode_fsm_tb_top;
  import cpm_pkg::*;
  typedef struct {
    logic [1:0] resp;
    logic [MODE_W-1:0] mode;
  } cpm_note_s;
  localparam logic [MODE_W-1:0] DBG_MODE = {3'h0, CLS_DBG};
  logic clock, resetn, cores_all_off, service_demand, idle_hint;
  logic memory_retention_wanted, mem_idle, mode_request, mode_accept, mode_deny;
  logic request_stall, debug_recovery_mode, invalidate_busy, inval_seen;
  logic [MODE_W-1:0] requested_mode_bus, required_mode_hint, current_mode;
  logic [MODE_W-1:0] cur, r;
  logic [WAY_GRP-1:0] way_power_on;
  logic coherent, l3_alloc_en;
  cpm_note_s exp_q[$];
  cpm_note_s n_mon;
  int fail_count, total_checks;
  int seed = 32'ha950feaf;
  cpm_mode_fsm i_cpm_mode_fsm (
    .clock(clock), .resetn(resetn),
    .requested_mode_bus(requested_mode_bus), .mode_request(mode_request),
    .cores_all_off(cores_all_off), .service_demand(service_demand),
    .idle_hint(idle_hint), .memory_retention_wanted(memory_retention_wanted),
    .mem_idle(mem_idle), .mode_accept(mode_accept), .mode_deny(mode_deny),
    .required_mode_hint(required_mode_hint), .current_mode(current_mode),
    .logic_power_on(), .sf_ram_on(), .way_power_on(way_power_on),
    .ram_retention(), .ram_clock_en(), .coherent(coherent),
    .l3_alloc_en(l3_alloc_en),
    .invalidate_busy(invalidate_busy), .request_stall(request_stall),
    .debug_recovery_mode(debug_recovery_mode)
  );
  cpm_ctrl_model i_cpm_ctrl_model (
    .clock(clock), .mode_accept(mode_accept), .mode_deny(mode_deny),
    .requested_mode_bus(requested_mode_bus), .mode_request(mode_request)
  );
  always #20 clock = ~clock;
  task automatic chk_val(input string nm, input logic [MODE_W-1:0] e, a);
    total_checks++;
    if (a !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, a);
    end
  endtask
  task automatic chk_resp(input logic [1:0] e, a);
    total_checks++;
    if (a !== e) begin
      fail_count++;
      $display("[FAIL] response expected %b seen %b", e, a);
    end
  endtask
  task automatic wrap_up();
    if (exp_q.size() != 0) fail_count++;
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic step(input logic [MODE_W-1:0] m, input logic ok);
    cpm_note_s n;
    n.resp = ok ? 2'b10 : 2'b01;
    n.mode = ok ? m : cur;
    cur = n.mode;
    exp_q.push_back(n);
    i_cpm_ctrl_model.request(m, {$random(seed)} % 4);
  endtask
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    repeat (12) @(posedge clock);
  endtask
  // Answer judged on its rise, resulting mode once the answer drops
  always @(posedge clock) begin
    if (invalidate_busy === 1'b1) inval_seen <= 1'b1;
    if ($rose(mode_accept) || $rose(mode_deny)) begin
      n_mon.resp = 2'b00;
      if (exp_q.size() > 0) n_mon = exp_q.pop_front();
      chk_resp(n_mon.resp, {mode_accept, mode_deny});
    end
    if ($fell(mode_accept) || $fell(mode_deny))
      chk_val("current_mode", n_mon.mode, current_mode);
  end
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    wrap_up();
  end
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    cores_all_off = 1'b0;
    service_demand = 1'b0;
    idle_hint = 1'b0;
    memory_retention_wanted = 1'b0;
    mem_idle = 1'b1;
    inval_seen = 1'b0;
    i_cpm_ctrl_model.preset(MODE_SF_ON);
    cur = MODE_SF_ON;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    repeat (12) @(posedge clock);
    chk_val("initial mode", MODE_SF_ON, current_mode);
    chk_val("ways", 7'h00, {3'h0, way_power_on});
    step(MODE_Q1_ON, 1'b1);
    step(MODE_HALF_ON, 1'b1);
    step(MODE_FULL_ON, 1'b0);
    step(MODE_Q3_ON, 1'b1);
    step(MODE_FULL_ON, 1'b1);
    chk_val("ways", 7'h0f, {3'h0, way_power_on});
    chk_val("coherent", 7'h01, {6'h00, coherent});
    repeat (6) begin
      r = 7'($random(seed));
      while (r == MODE_Q3_ON || r == MODE_FULL_FRET || r == MODE_FULL_ON
             || r[3:0] == CLS_DBG)
        r = 7'($random(seed));
      step(r, 1'b0);
    end
    step(MODE_Q3_ON, 1'b1);
    step(MODE_HALF_ON, 1'b1);
    mem_idle <= 1'b0;
    fork
      step(MODE_HALF_FRET, 1'b1);
      begin
        repeat (40) @(posedge clock);
        mem_idle <= 1'b1;
      end
    join
    idle_hint <= 1'b1;
    service_demand <= 1'b1;
    repeat (12) @(posedge clock);
    chk_val("hint", MODE_HALF_ON, required_mode_hint);
    chk_val("stall", 7'h01, {6'h00, request_stall});
    step(MODE_HALF_ON, 1'b1);
    service_demand <= 1'b0;
    repeat (12) @(posedge clock);
    chk_val("stall", 7'h00, {6'h00, request_stall});
    step(MODE_HALF_MRET, 1'b0);
    cores_all_off <= 1'b1;
    memory_retention_wanted <= 1'b1;
    repeat (8) @(posedge clock);
    step(MODE_HALF_MRET, 1'b1);
    step(MODE_HALF_ON, 1'b1);
    step(MODE_OFF, 1'b1);
    chk_val("coh alloc", 7'h00, {5'h00, coherent, l3_alloc_en});
    inval_seen = 1'b0;
    step(MODE_SF_ON, 1'b1);
    chk_val("invalidate", 7'h01, {6'h00, inval_seen});
    step(DBG_MODE, 1'b1);
    do_reset();
    chk_val("initial mode", DBG_MODE, current_mode);
    chk_val("debug", 7'h01, {6'h00, debug_recovery_mode});
    inval_seen = 1'b0;
    step(MODE_HALF_ON, 1'b1);
    chk_val("coh alloc", 7'h03, {5'h00, coherent, l3_alloc_en});
    chk_val("invalidate", 7'h00, {6'h00, inval_seen});
    wrap_up();
  end
endmodule // cluster_power_mode_fsm_tb_top
